/* File: hw/memcard_pins.sv */
// Pin sequencer for static memory, DRAM and two card sockets.
// Assumes requests come from an on-chip controller and that all pin
// inputs are already synchronous to clk_in.
// Contract
// - Drive 26-bit address; DRAM row and column multiplexed on bits 21..10.
// - Four active-low static chip selects, each chosen per request.
// - Output enable low tells the addressed memory to drive read data.
// - DRAM writes assert write enable with only the written bytes' column strobes.
// - Pulse card memory read strobe low for memory or attribute reads.
// - Pulse card memory write strobe low for memory or attribute writes.
// - Card I/O write and read strobes low for I/O writes and reads.
// - Two active-low card enables, one per byte lane.
// - Card 16-bit I/O acknowledge input is reported as the I/O width.
// - Card cycle stretches while the card holds wait low.
// - Socket select picks socket zero low, one high, timed like address.
// - Attribute select marks attribute-space card memory cycles, timed like address.
// - Four row strobes and four column strobes drive the DRAM banks.
`timescale 1ns/10ps
`default_nettype none
module memcard_pins
  import memcard_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              req_valid_in,
  input  wire req_t              req_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output var  logic              req_ready_out,
  output var  logic              rsp_valid_out,
  output var  logic [DATA_W-1:0] rdata_out,
  output var  logic              io16_out,
  output var  logic [ADDR_W-1:0] mem_addr_out,
  input  wire logic [DATA_W-1:0] data_in,
  output var  logic [DATA_W-1:0] data_out,
  output var  logic              data_oe_n_out,
  output var  logic [3:0]        static_chip_select_n_out,
  output var  logic              mem_output_enable_n_out,
  output var  logic              dram_write_enable_n_out,
  output var  logic [3:0]        row_strobe_n_out,
  output var  logic [3:0]        col_strobe_n_out,
  output var  logic              card_mem_read_strobe_n_out,
  output var  logic              card_mem_write_strobe_n_out,
  output var  logic              card_io_write_strobe_n_out,
  output var  logic              card_io_read_strobe_n_out,
  output var  logic [1:0]        card_byte_lane_enable_n_out,
  input  wire logic              io_width16_ack_n_in,
  input  wire logic              card_wait_n_in,
  output var  logic              socket_select_out,
  output var  logic              attribute_space_select_out
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic is_dram(kind_t k);
    return (k == K_DRAM_RD) || (k == K_DRAM_WR);
  endfunction : is_dram

  function automatic logic is_card(kind_t k);
    return (k == K_CARD_MEM_RD) || (k == K_CARD_MEM_WR) ||
           (k == K_CARD_IO_RD) || (k == K_CARD_IO_WR);
  endfunction : is_card

  function automatic logic is_io(kind_t k);
    return (k == K_CARD_IO_RD) || (k == K_CARD_IO_WR);
  endfunction : is_io

  function automatic logic is_write(kind_t k);
    return (k == K_STATIC_WR) || (k == K_DRAM_WR) ||
           (k == K_CARD_MEM_WR) || (k == K_CARD_IO_WR);
  endfunction : is_write

  // DRAM address field: row or column part of the byte address on bits 21..10.
  function automatic logic [ADDR_W-1:0] dram_addr(logic [ADDR_W-1:0] a,
                                                  logic col);
    logic [11:0] f;
    f = col ? a[COL_LSB +: 12] : a[ROW_LSB +: 12];
    return {4'h0, f, 10'h000};
  endfunction : dram_addr

  // Asserts or releases the strobes that belong to the request's kind.
  function automatic pins_t strobe(pins_t p, req_t r, logic on);
    pins_t q;
    q = p;
    case (r.kind)
      K_STATIC_RD:
      begin
        q.cs_n[r.bank] = ~on;
        q.oe_n         = ~on;
      end
      K_STATIC_WR:
      begin
        q.cs_n[r.bank] = ~on;
        q.we_n         = ~on;
      end
      K_DRAM_RD:
      begin
        q.cas_n = on ? ~r.be : 4'hf;
        q.oe_n  = ~on;
      end
      K_DRAM_WR:
      begin
        q.cas_n = on ? ~r.be : 4'hf;
        q.we_n  = ~on;
      end
      K_CARD_MEM_RD: q.mrd_n  = ~on;
      K_CARD_MEM_WR: q.mwr_n  = ~on;
      K_CARD_IO_WR:  q.iowr_n = ~on;
      K_CARD_IO_RD:  q.iord_n = ~on;
      default:       q = p;
    endcase
    return q;
  endfunction : strobe

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  state_t st_reg;
  state_t st_next;

  always_comb
  begin
    st_next     = st_reg;
    st_next.rsp = 1'b0;
    case (st_reg.phase)
      PH_IDLE:
      begin
        if (req_valid_in)
        begin
          st_next.req   = req_in;
          st_next.ready = 1'b0;
          st_next.phase = PH_SETUP;
          st_next.cnt   = SETUP_CYCLES;
          // Socket and attribute change together with the address.
          st_next.pins.addr = is_dram(req_in.kind) ?
                              dram_addr(req_in.a, 1'b0) : req_in.a;
          st_next.pins.sock = req_in.sock;
          st_next.pins.attr = req_in.attr &&
                              (req_in.kind == K_CARD_MEM_RD ||
                               req_in.kind == K_CARD_MEM_WR);
          if (is_card(req_in.kind))
          begin
            st_next.pins.lane_n = ~req_in.be[1:0];
          end
          if (is_write(req_in.kind))
          begin
            st_next.pins.dout  = wdata_in;
            st_next.pins.doe_n = 1'b0;
          end
        end
      end
      PH_SETUP:
      begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt <= 4'h1)
        begin
          if (is_dram(st_reg.req.kind))
          begin
            st_next.pins.ras_n[st_reg.req.bank] = 1'b0;
            st_next.phase = PH_ROW;
          end
          else
          begin
            st_next.pins  = strobe(st_reg.pins, st_reg.req, 1'b1);
            st_next.phase = PH_STROBE;
            st_next.cnt   = STROBE_CYCLES;
          end
        end
      end
      PH_ROW:
      begin
        // Row is latched by now; the column follows with its strobes.
        st_next.pins      = strobe(st_reg.pins, st_reg.req, 1'b1);
        st_next.pins.addr = dram_addr(st_reg.req.a, 1'b1);
        st_next.phase     = PH_STROBE;
        st_next.cnt       = STROBE_CYCLES;
      end
      PH_STROBE:
      begin
        if (st_reg.cnt > 4'h1)
        begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end
        else if (!is_card(st_reg.req.kind) || card_wait_n_in)
        begin
          st_next.pins = strobe(st_reg.pins, st_reg.req, 1'b0);
          if (!is_write(st_reg.req.kind))
          begin
            st_next.rdata = data_in;
          end
          if (is_io(st_reg.req.kind))
          begin
            st_next.io16 = ~io_width16_ack_n_in;
          end
          st_next.phase = PH_HOLD;
          st_next.cnt   = HOLD_CYCLES;
        end
      end
      PH_HOLD:
      begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt <= 4'h1)
        begin
          st_next.pins.ras_n  = 4'hf;
          st_next.pins.lane_n = 2'h3;
          st_next.pins.doe_n  = 1'b1;
          st_next.phase       = PH_IDLE;
          st_next.ready       = 1'b1;
          st_next.rsp         = 1'b1;
        end
      end
      default: st_next = ST_RESET;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_reg <= ST_RESET;
    else
      st_reg <= st_next;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign req_ready_out               = st_reg.ready;
  assign rsp_valid_out               = st_reg.rsp;
  assign rdata_out                   = st_reg.rdata;
  assign io16_out                    = st_reg.io16;
  assign mem_addr_out                = st_reg.pins.addr;
  assign data_out                    = st_reg.pins.dout;
  assign data_oe_n_out               = st_reg.pins.doe_n;
  assign static_chip_select_n_out    = st_reg.pins.cs_n;
  assign mem_output_enable_n_out     = st_reg.pins.oe_n;
  assign dram_write_enable_n_out     = st_reg.pins.we_n;
  assign row_strobe_n_out            = st_reg.pins.ras_n;
  assign col_strobe_n_out            = st_reg.pins.cas_n;
  assign card_mem_read_strobe_n_out  = st_reg.pins.mrd_n;
  assign card_mem_write_strobe_n_out = st_reg.pins.mwr_n;
  assign card_io_write_strobe_n_out  = st_reg.pins.iowr_n;
  assign card_io_read_strobe_n_out   = st_reg.pins.iord_n;
  assign card_byte_lane_enable_n_out = st_reg.pins.lane_n;
  assign socket_select_out           = st_reg.pins.sock;
  assign attribute_space_select_out  = st_reg.pins.attr;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_in_strobe;
    st_reg.phase == PH_STROBE && $past(st_reg.phase) == PH_STROBE;
  endsequence

  sequence s_io_end;
    st_reg.phase == PH_STROBE && st_reg.cnt == 4'h1 &&
    is_io(st_reg.req.kind) && card_wait_n_in;
  endsequence

  AST_DRAM_ROW: assert property (
    st_reg.phase == PH_ROW |-> st_reg.pins.addr == dram_addr(st_reg.req.a, 1'b0)
  ) else $error("DRAM row address not on bits 21..10.");

  AST_CS_ONE: assert property (
    st_reg.pins.cs_n != 4'hf |->
      $onehot(~st_reg.pins.cs_n) && st_reg.pins.cs_n[st_reg.req.bank] == 1'b0
  ) else $error("Static chip select not the requested one.");

  AST_OE_READ: assert property (
    !st_reg.pins.oe_n |-> st_reg.pins.doe_n && !is_write(st_reg.req.kind)
  ) else $error("Output enable low while not a read.");

  AST_CAS_BYTES: assert property (
    st_reg.phase == PH_STROBE && st_reg.req.kind == K_DRAM_WR |->
      !st_reg.pins.we_n && (~st_reg.pins.cas_n == st_reg.req.be)
  ) else $error("DRAM write strobes do not match byte enables.");

  AST_CARD_MRD: assert property (
    $fell(st_reg.pins.mrd_n) |-> (st_reg.req.kind == K_CARD_MEM_RD) ##0
      (!st_reg.pins.mrd_n) [*3]
  ) else $error("Card memory read strobe wrong or too short.");

  AST_CARD_MWR: assert property (
    !st_reg.pins.mwr_n |-> st_reg.req.kind == K_CARD_MEM_WR && !st_reg.pins.doe_n
  ) else $error("Card memory write strobe without write data.");

  AST_CARD_IO: assert property (
    (!st_reg.pins.iowr_n |-> st_reg.req.kind == K_CARD_IO_WR) and
    (!st_reg.pins.iord_n |-> st_reg.req.kind == K_CARD_IO_RD)
  ) else $error("Card I/O strobe on wrong cycle kind.");

  AST_LANES: assert property (
    st_reg.pins.lane_n != 2'h3 |->
      is_card(st_reg.req.kind) && st_reg.pins.lane_n == ~st_reg.req.be[1:0]
  ) else $error("Card lane enables wrong.");

  AST_IO16: assert property (
    s_io_end |=> st_reg.io16 == !$past(io_width16_ack_n_in)
  ) else $error("Card 16-bit I/O acknowledge not captured.");

  AST_WAIT: assert property (
    st_reg.phase == PH_STROBE && is_card(st_reg.req.kind) && !card_wait_n_in
      |=> st_reg.phase == PH_STROBE
  ) else $error("Card cycle ended while wait was low.");

  AST_SOCK_ATTR: assert property (
    s_in_strobe |-> $stable(st_reg.pins.sock) && $stable(st_reg.pins.attr) &&
      $stable(st_reg.pins.addr)
  ) else $error("Socket or attribute select moved during strobe.");

  AST_RAS_CAS: assert property (
    st_reg.pins.cas_n != 4'hf && is_dram(st_reg.req.kind) |->
      st_reg.pins.ras_n[st_reg.req.bank] == 1'b0
  ) else $error("Column strobe without row strobe.");

  AST_CARD_IDLE: assert property (
    st_reg.phase == PH_IDLE |->
      &{st_reg.pins.mrd_n, st_reg.pins.mwr_n, st_reg.pins.iowr_n,
        st_reg.pins.iord_n, st_reg.pins.lane_n}
  ) else $error("Card strobe or enable active while idle.");

endmodule : memcard_pins
`default_nettype wire

/* File: hw/memcard_pkg.sv */
// Types and constants of the memory and card-slot pin sequencer.
// Assumes one 40 MHz clock and a requester that presents one cycle at a time.
package memcard_pkg;

  // ==========================================================================
  // Widths and timing
  // ==========================================================================
  localparam int ADDR_W  = 26;
  localparam int DATA_W  = 32;
  localparam int ROW_LSB = 14;
  localparam int COL_LSB = 2;
  // Cycle counts of the setup, strobe and hold phases at 25 ns per cycle.
  localparam logic [3:0] SETUP_CYCLES  = 4'h1;
  localparam logic [3:0] STROBE_CYCLES = 4'h3;
  localparam logic [3:0] HOLD_CYCLES   = 4'h1;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [2:0] {
    K_STATIC_RD, K_STATIC_WR, K_DRAM_RD, K_DRAM_WR,
    K_CARD_MEM_RD, K_CARD_MEM_WR, K_CARD_IO_RD, K_CARD_IO_WR
  } kind_t;

  typedef enum logic [2:0] {
    PH_IDLE, PH_SETUP, PH_ROW, PH_STROBE, PH_HOLD
  } phase_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    kind_t             kind;
    logic [1:0]        bank;
    logic [3:0]        be;
    logic              sock;
    logic              attr;
    logic [ADDR_W-1:0] a;
  } req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0]        cs_n;
    logic              oe_n;
    logic              we_n;
    logic [3:0]        ras_n;
    logic [3:0]        cas_n;
    logic              mrd_n;
    logic              mwr_n;
    logic              iowr_n;
    logic              iord_n;
    logic [1:0]        lane_n;
    logic              sock;
    logic              attr;
    logic [DATA_W-1:0] dout;
    logic              doe_n;
  } pins_t;

  typedef struct packed {
    phase_t            phase;
    logic [3:0]        cnt;
    req_t              req;
    pins_t             pins;
    logic              ready;
    logic              rsp;
    logic [DATA_W-1:0] rdata;
    logic              io16;
  } state_t;

  localparam pins_t PINS_IDLE = '{addr: '0, cs_n: 4'hf, oe_n: 1'b1,
    we_n: 1'b1, ras_n: 4'hf, cas_n: 4'hf, mrd_n: 1'b1, mwr_n: 1'b1,
    iowr_n: 1'b1, iord_n: 1'b1, lane_n: 2'h3, sock: 1'b0, attr: 1'b0,
    dout: '0, doe_n: 1'b1};

  localparam state_t ST_RESET = '{phase: PH_IDLE, cnt: 4'h0, req: '0,
    pins: PINS_IDLE, ready: 1'b1, rsp: 1'b0, rdata: '0, io16: 1'b0};

endpackage : memcard_pkg

/* File: sim/memcard_far_model.sv */
// Far-side model: static memory, DRAM and card sockets seen at the pins.
// Assumes the bench sets the read word, the wait length and the 16-bit flag.
`timescale 1ns/10ps
`default_nettype none
module memcard_far_model
  import memcard_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              oe_n_in,
  input  wire logic [3:0]        card_n_in,
  input  wire logic [DATA_W-1:0] word_in,
  input  wire logic [3:0]        stretch_in,
  input  wire logic              wide_in,
  output var  logic [DATA_W-1:0] data_out,
  output var  logic              wait_n_out,
  output var  logic              ack16_n_out
);
  // ==========================================================================
  // Bus and card answers
  // ==========================================================================
  logic [DATA_W-1:0] last_reg;
  logic [4:0]        cnt_reg;
  wire logic         rd_sel  = !oe_n_in || !card_n_in[3] || !card_n_in[1];
  wire logic         card_on = card_n_in != 4'hf;
  // A released bus shows the inverse of its last value, so stale data never matches.
  assign data_out    = rd_sel ? word_in : ~last_reg;
  // Wait is held low past the strobe end for stretch_in extra cycles.
  assign wait_n_out  = !(card_on && cnt_reg < 5'h2 + {1'b0, stretch_in});
  assign ack16_n_out = !(wide_in && card_n_in[1:0] != 2'h3);
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      last_reg <= '0;
      cnt_reg  <= '0;
    end
    else
    begin
      if (rd_sel)
        last_reg <= word_in;
      cnt_reg <= card_on ? cnt_reg + 5'h1 : 5'h0;
    end
  end
endmodule : memcard_far_model
`default_nettype wire

/* File: sim/tb_memory_and_card_pin_signaling.sv */
// Self-checking bench for the memory and card pin sequencer.
// Assumes memcard_pins and memcard_far_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_memory_and_card_pin_signaling;
  import memcard_pkg::*;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic clk_in, rst_in, req_valid_in, req_ready_out, rsp_valid_out, io16_out;
  logic oe_n, we_n, mrd_n, mwr_n, iowr_n, iord_n, wait_n, ack_n, sock, attr, wide;
  req_t req_in;
  logic [DATA_W-1:0] wdata_in, rdata_out, data_in, rd_word, dout, wd_v;
  logic [ADDR_W-1:0] addr, adr_v, row_v, col_v;
  logic [3:0] cs_n, ras_n, cas_n, stretch, cs_a, ras_a, cas_v, str_a;
  logic [1:0] lane_n, ln_a, lane_v;
  logic oe_a, we_a, sk_v, at_v, doe_n, doe_a;
  int lat, miscompares, checks_done;
  memcard_pins uut (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .wdata_in(wdata_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rdata_out(rdata_out), .io16_out(io16_out),
    .mem_addr_out(addr), .data_in(data_in), .data_out(dout), .data_oe_n_out(doe_n),
    .static_chip_select_n_out(cs_n), .mem_output_enable_n_out(oe_n),
    .dram_write_enable_n_out(we_n), .row_strobe_n_out(ras_n), .col_strobe_n_out(cas_n),
    .card_mem_read_strobe_n_out(mrd_n), .card_mem_write_strobe_n_out(mwr_n),
    .card_io_write_strobe_n_out(iowr_n), .card_io_read_strobe_n_out(iord_n),
    .card_byte_lane_enable_n_out(lane_n), .io_width16_ack_n_in(ack_n),
    .card_wait_n_in(wait_n), .socket_select_out(sock), .attribute_space_select_out(attr));
  memcard_far_model far (.clk_in(clk_in), .rst_in(rst_in), .oe_n_in(oe_n),
    .card_n_in({mrd_n, mwr_n, iord_n, iowr_n}), .word_in(rd_word), .stretch_in(stretch),
    .wide_in(wide), .data_out(data_in), .wait_n_out(wait_n), .ack16_n_out(ack_n));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Presents one request, then records what the pins did until the response.
  task automatic run(input kind_t k, input logic [1:0] bk, input logic [3:0] be,
                     input logic sk, input logic at, input logic [25:0] a);
    int i;
    if (req_ready_out !== 1'b1)
    begin
      miscompares++;
      end_sim();
    end
    req_in = '{kind: k, bank: bk, be: be, sock: sk, attr: at, a: a};
    wdata_in = {a[5:0], a};
    rd_word = {a[5:0], a};
    req_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    req_valid_in = 1'b0;
    {cs_a, ras_a, cas_v, str_a, ln_a, oe_a, we_a, doe_a} = '1;
    wd_v = '0;
    for (i = 0; i < 40 && rsp_valid_out !== 1'b1; i++)
    begin
      doe_a &= doe_n;
      if (!doe_n)
        wd_v = dout;
      cs_a &= cs_n;
      ras_a &= ras_n;
      oe_a &= oe_n;
      we_a &= we_n;
      ln_a &= lane_n;
      str_a &= {mrd_n, mwr_n, iord_n, iowr_n};
      if (cas_n != 4'hf)
      begin
        cas_v = cas_n;
        col_v = addr;
      end
      else if (ras_n != 4'hf && cas_v === 4'hf)
        row_v = addr;
      if (cs_n != 4'hf || {mrd_n, mwr_n, iord_n, iowr_n} != 4'hf)
        {adr_v, lane_v, sk_v, at_v} = {addr, lane_n, sock, attr};
      @(posedge clk_in);
      #1;
    end
    lat = i;
    if (rsp_valid_out !== 1'b1)
    begin
      miscompares++;
      end_sim();
    end
    chk("card pins at response", {mrd_n, mwr_n, iord_n, iowr_n, lane_n}, 6'h3f);
    chk("data drive", doe_a, !k[0]);
    if (k[0])
      chk("write data", wd_v, {a[5:0], a});
  endtask : run
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_static();
    logic [3:0] sel;
    logic [25:0] a;
    for (int i = 0; i < 8; i++)
    begin
      sel = ~(4'h1 << i[2:1]);
      a = 26'h2a5_5a30 + 26'(i);
      run(i[0] ? K_STATIC_WR : K_STATIC_RD, i[2:1], 4'hf, 1'b0, 1'b0, a);
      chk("chip selects", cs_a, sel);
      chk("output enable", oe_a, i[0]);
      chk("write enable", we_a, !i[0]);
      chk("address", adr_v, a);
      chk("card pins in static cycle", {str_a, ln_a}, 6'h3f);
      chk("static latency", lat, 5);
      if (!i[0])
        chk("static read data", rdata_out, {a[5:0], a});
    end
    $display("test static done");
  endtask : test_static
  task automatic test_dram();
    logic [3:0] bes [4] = '{4'h5, 4'ha, 4'hf, 4'h8};
    logic [3:0] sel, nbe;
    logic [25:0] a;
    for (int b = 0; b < 4; b++)
    begin
      sel = ~(4'h1 << b);
      nbe = ~bes[b];
      a = 26'h3c9_6a5c ^ 26'(b << 14);
      run(b[0] ? K_DRAM_WR : K_DRAM_RD, b[1:0], bes[b], 1'b0, 1'b0, a);
      chk("row strobes", ras_a, sel);
      chk("column strobes", cas_v, nbe);
      chk("dram write enable", we_a, !b[0]);
      chk("dram output enable", oe_a, b[0]);
      chk("row address", row_v[21:10], a[25:14]);
      chk("column address", col_v[21:10], a[13:2]);
      chk("chip selects in dram cycle", cs_a, 4'hf);
      chk("card pins in dram cycle", {str_a, ln_a}, 6'h3f);
      chk("dram latency", lat, 6);
      if (!b[0])
        chk("dram read data", rdata_out, {a[5:0], a});
    end
    $display("test dram done");
  endtask : test_dram
  // Card cycles: io selects I/O space; the last pass uses no byte lane.
  task automatic test_card(input logic io);
    logic [3:0] be;
    logic [25:0] a;
    for (int i = 0; i < 4; i++)
    begin
      be = 4'(i + 1);
      a = 26'h155_0c00 + 26'(i);
      stretch = io ? (i[1] ? 4'h4 : 4'(i)) : 4'h0;
      wide = io & i[1];
      run(kind_t'({1'b1, io, i[0]}), 2'h0, be, i[1], i[0] ^ i[1], a);
      chk("card strobes", str_a, io ? {2'h3, i[0], !i[0]} : {i[0], !i[0], 2'h3});
      chk("byte lanes", lane_v, be[1:0] ^ 2'h3);
      chk("socket select", sk_v, i[1]);
      chk("attribute select", at_v, !io & (i[0] ^ i[1]));
      chk("card address", adr_v, a);
      chk("card latency", lat, 5 + stretch);
      if (io)
        chk("io width", io16_out, wide);
      if (!i[0])
        chk("card read data", rdata_out, {a[5:0], a});
    end
    $display("test card io=%0d done", io);
  endtask : test_card
  // Reset in mid-cycle: every strobe drops at once and the next cycle runs clean.
  task automatic test_reset();
    {stretch, wide} = '0;
    req_in = '{kind: K_CARD_IO_RD, bank: 2'h0, be: 4'h3, sock: 1'b1, attr: 1'b0,
               a: 26'h0a5_0f0f};
    req_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    req_valid_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("io read strobe before reset", {iord_n, lane_n}, 3'h0);
    rst_in = 1'b1;
    #1;
    chk("card pins in reset", {mrd_n, mwr_n, iord_n, iowr_n, lane_n}, 6'h3f);
    chk("handshake in reset", {req_ready_out, rsp_valid_out, sock, attr}, 4'h8);
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    chk("address after reset", addr, 26'h000_0000);
    run(K_STATIC_RD, 2'h2, 4'hf, 1'b0, 1'b0, 26'h1c3_3c0c);
    chk("chip selects after reset", cs_a, 4'hb);
    chk("read data after reset", rdata_out, {6'h0c, 26'h1c3_3c0c});
    $display("test reset done");
  endtask : test_reset
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial
  begin
    {rst_in, req_valid_in, wide, req_in, wdata_in, rd_word, stretch} = '0;
    {miscompares, checks_done} = '0;
    rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    chk("pins after reset", {cs_n, oe_n, we_n, ras_n, cas_n, doe_n}, 15'h7fff);
    chk("card strobes after reset", {mrd_n, mwr_n, iord_n, iowr_n, lane_n}, 6'h3f);
    chk("handshake after reset", {req_ready_out, rsp_valid_out, sock, attr}, 4'h8);
    test_static();
    test_dram();
    test_card(1'b0);
    test_card(1'b1);
    test_reset();
    end_sim();
  end
endmodule : tb_memory_and_card_pin_signaling
`default_nettype wire
